// >>> tb_top.sv
// self-checking bench for the crosspoint programming logic
module tb_top import xp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic                  rank_update_n = 1'b1;
    logic                  rank_clear_n = 1'b1;
    logic                  load_clk, chip_select_n, load_mode_select, serial_in, output_enable_bit;
    logic [SEL_W-1:0]      output_address, input_select_bits;
    logic                  serial_out, rank_follow;
    logic [N_OUT-1:0]      out_enable;
    logic [N_OUT*N_IN-1:0] in_route;
    logic [SR_BITS-1:0]    wa, wb, wc;
    logic [SEL_W-1:0]      r, a;
    logic [SLOT_W-1:0]     d;
    logic                  q_so[$];
    logic [SR_BITS-1:0]    q_rank[$];
    int                    err_total = 0;
    int                    total_checks = 0;

    always #20 mclk = ~mclk;

    xp_host_model host (.load_clk(load_clk), .chip_select_n(chip_select_n), .load_mode_select(load_mode_select),
        .serial_in(serial_in), .output_address(output_address), .input_select_bits(input_select_bits),
        .output_enable_bit(output_enable_bit));

    xp_crosspoint_prog dut (.mclk(mclk), .rst(rst), .load_clk(load_clk), .chip_select_n(chip_select_n),
        .rank_update_n(rank_update_n), .rank_clear_n(rank_clear_n), .load_mode_select(load_mode_select),
        .serial_in(serial_in), .output_address(output_address), .input_select_bits(input_select_bits),
        .output_enable_bit(output_enable_bit), .serial_out(serial_out), .out_enable(out_enable),
        .in_route(in_route), .rank_follow(rank_follow));

    // ==========================================
    // expected second rank from a first-rank word
    function automatic logic [N_OUT-1:0] en_of(input logic [SR_BITS-1:0] w);
        for (int n = 0; n < N_OUT; n++) en_of[n] = w[SLOT_W*n+EN_POS];
    endfunction

    function automatic logic [N_OUT*N_IN-1:0] route_of(input logic [SR_BITS-1:0] w);
        route_of = '0;
        for (int n = 0; n < N_OUT; n++) begin
            if (w[SLOT_W*n+EN_POS]) route_of[N_IN*n+w[SLOT_W*n+:SEL_W]] = 1'b1;
        end
    endfunction

    // ==========================================
    // compare and report
    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rank(input string nm, input logic [SR_BITS-1:0] w);
        total_checks++;
        if (out_enable !== en_of(w) || in_route !== route_of(w)) begin
            err_total++;
            $display("CHECK FAILED %s expected %h %h seen %h %h", nm, en_of(w), route_of(w), out_enable, in_route);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_q();
        for (int i = 0; i < 40 && q_rank.size() > 0; i++) @(negedge mclk);
        if (q_rank.size() > 0) begin
            err_total++;
            $display("CHECK FAILED second rank expected capture seen none");
            summarize();
        end
    endtask

    // ==========================================
    // watchers
    always @(negedge load_clk) begin
        if (chip_select_n === 1'b0 && q_so.size() > 0) begin
            #1 chk_bit("serial_out", q_so.pop_front(), serial_out);
        end
    end

    always @(posedge rank_follow) begin
        #1;
        if (q_rank.size() > 0) begin
            chk_rank("second rank", q_rank.pop_front());
        end else begin
            err_total++;
            $display("CHECK FAILED rank_follow expected 0 seen 1");
        end
    end

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'hd452cc35));
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        host.pulse();
        chk_rank("after reset", '0);
        host.select(1'b0);
        r = 4'($urandom);
        for (int n = 0; n < N_OUT; n++) wa[SLOT_W*n+:SLOT_W] = {(n % 4) != 0, 4'(n) ^ r};
        host.send_word(wa);
        q_rank.push_back(wa);
        @(negedge mclk) rank_update_n = 1'b0;
        wait_q();
        @(negedge mclk) rank_update_n = 1'b1;
        repeat (4) @(negedge mclk);
        wb = SR_BITS'({$urandom, $urandom, $urandom});
        for (int k = SR_BITS - 2; k >= 0; k--) q_so.push_back(wa[k]);
        q_so.push_back(wb[SR_BITS-1]);
        host.send_word(wb);
        chk_rank("held", wa);
        host.select(1'b1);
        host.shift_bit(~wb[SR_BITS-1]);
        chk_bit("serial_out", wb[SR_BITS-1], serial_out);
        @(negedge mclk) rank_update_n = 1'b0;
        repeat (12) @(negedge mclk);
        chk_rank("deselected", wa);
        chk_bit("rank_follow", 1'b0, rank_follow);
        q_rank.push_back(wb);
        host.select(1'b0);
        wait_q();
        @(negedge mclk) rank_update_n = 1'b1;
        wc = wb;
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 4'hf : 4'($urandom_range(14));
            d = 5'($urandom);
            if (i == 0) d[EN_POS] = ~wb[SR_BITS-1];
            wc[SLOT_W*a+:SLOT_W] = d;
            host.par_write(a, d[EN_POS], d[SEL_W-1:0]);
        end
        chk_bit("serial_out", wc[SR_BITS-1], serial_out);
        q_rank.push_back(wc);
        @(negedge mclk) rank_update_n = 1'b0;
        wait_q();
        @(negedge mclk) rank_update_n = 1'b1;
        repeat (4) @(negedge mclk);
        #13 rank_clear_n = 1'b0;
        #2 chk_rank("clear", '0);
        @(negedge mclk) rank_clear_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk_rank("cleared", '0);
        q_rank.push_back(wc);
        rank_update_n = 1'b0;
        wait_q();
        summarize();
    end
endmodule

// >>> xp_crosspoint_prog.sv
// crosspoint programming logic: two-rank switch control with serial and parallel load
module xp_crosspoint_prog import xp_pkg::*; (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    load_clk,
    input  wire logic                    chip_select_n,
    input  wire logic                    rank_update_n,
    input  wire logic                    rank_clear_n,
    input  wire logic                    load_mode_select,
    input  wire logic                    serial_in,
    input  wire logic [SEL_W-1:0]        output_address,
    input  wire logic [SEL_W-1:0]        input_select_bits,
    input  wire logic                    output_enable_bit,
    output wire logic                    serial_out,
    output wire logic [N_OUT-1:0]        out_enable,
    output wire logic [N_OUT*N_IN-1:0]   in_route,
    output wire logic                    rank_follow
);
    // =========================================================
    // declarations
    xp_link_if lnk ();

    logic [SY_W-1:0]   sy1_ff;
    logic [SY_W-1:0]   nxt_sy1;
    logic [SY_W-1:0]   sy2_ff;
    logic [SY_W-1:0]   nxt_sy2;
    logic              tdly_ff;
    logic              nxt_tdly;
    logic [1:0]        clr_ff;
    logic [1:0]        nxt_clr;
    logic              rs_n;
    logic [QCNT_W-1:0] q_ff;
    logic [QCNT_W-1:0] nxt_q;
    xp_rank_st_t       st_ff;
    xp_rank_st_t       nxt_st;
    logic              chg;
    logic              quiet;
    logic              open_win;
    logic              capture;

    // =========================================================
    // first rank on the load clock
    xp_link_shift u_shift (
        .load_clk          (load_clk),
        .chip_select_n     (chip_select_n),
        .load_mode_select  (load_mode_select),
        .serial_in         (serial_in),
        .output_address    (output_address),
        .input_select_bits (input_select_bits),
        .output_enable_bit (output_enable_bit),
        .lnk               (lnk.link),
        .serial_out        (serial_out)
    );

    // =========================================================
    // pin and toggle synchronisers
    always_comb begin
        nxt_sy1 = SY_RST;
        nxt_sy2 = SY_RST;
        nxt_tdly = 1'b0;
        if (!rst) begin
            nxt_sy1[SY_CE]  = chip_select_n;
            nxt_sy1[SY_UPD] = rank_update_n;
            nxt_sy1[SY_TOG] = lnk.chg_tog;
            nxt_sy2  = sy1_ff;
            nxt_tdly = sy2_ff[SY_TOG];
        end
    end

    always_ff @(posedge mclk) begin
        sy1_ff  <= nxt_sy1;
        sy2_ff  <= nxt_sy2;
        tdly_ff <= nxt_tdly;
    end

    // =========================================================
    // clear pin: asserts at once, releases on mclk
    always_comb begin
        nxt_clr = {clr_ff[0], 1'b1};
    end

    always_ff @(posedge mclk or negedge rank_clear_n) begin
        if (!rank_clear_n) begin
            clr_ff <= 2'h0;
        end else begin
            clr_ff <= nxt_clr;
        end
    end

    assign rs_n = clr_ff[1];

    // =========================================================
    // quiet time on mclk after the last load clock change
    // the first-rank word is sampled only after it stood still
    assign chg   = sy2_ff[SY_TOG] ^ tdly_ff;
    assign quiet = (q_ff == QCNT_W'(QUIET_CYC));

    always_comb begin
        nxt_q = q_ff;
        if (rst || chg) begin
            nxt_q = '0;
        end else if (!quiet) begin
            nxt_q = q_ff + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        q_ff <= nxt_q;
    end

    // =========================================================
    // second-rank window
    assign open_win = !sy2_ff[SY_CE] && !sy2_ff[SY_UPD] && rs_n;
    assign capture  = (st_ff == XP_WAIT) && open_win && quiet && !chg;

    always_comb begin
        nxt_st = st_ff;
        if (rst) begin
            nxt_st = XP_HOLD;
        end else begin
            case (st_ff)
                XP_HOLD: begin
                    if (open_win) begin
                        nxt_st = XP_WAIT;
                    end
                end
                XP_WAIT: begin
                    if (!open_win) begin
                        nxt_st = XP_HOLD;
                    end else if (quiet && !chg) begin
                        nxt_st = XP_PASS;
                    end
                end
                XP_PASS: begin
                    if (!open_win) begin
                        nxt_st = XP_HOLD;
                    end else if (chg) begin
                        // first rank moved: follow it again once quiet
                        nxt_st = XP_WAIT;
                    end
                end
                default: begin
                    nxt_st = XP_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    assign rank_follow = st_ff[2];

    // =========================================================
    // second rank and decode, one slice per output
    genvar o;
    generate
        for (o = 0; o < N_OUT; o++) begin : g_out
            logic             en_ff;
            logic             nxt_en;
            logic [SEL_W-1:0] sel_ff;
            logic [SEL_W-1:0] nxt_sel;
            logic [N_IN-1:0]  route_ff;
            logic [N_IN-1:0]  nxt_route;

            always_comb begin
                nxt_en    = en_ff;
                nxt_sel   = sel_ff;
                nxt_route = route_ff;
                if (rst) begin
                    nxt_en    = 1'b0;
                    nxt_sel   = '0;
                    nxt_route = '0;
                end else if (capture) begin
                    nxt_en  = lnk.word[o*SLOT_W+EN_POS];
                    nxt_sel = lnk.word[o*SLOT_W +: SEL_W];
                    if (nxt_en) begin
                        nxt_route = SEL_BASE << nxt_sel;
                    end else begin
                        nxt_route = '0;
                    end
                end
            end

            always_ff @(posedge mclk or negedge rs_n) begin
                if (!rs_n) begin
                    en_ff    <= 1'b0;
                    sel_ff   <= '0;
                    route_ff <= '0;
                end else begin
                    en_ff    <= nxt_en;
                    sel_ff   <= nxt_sel;
                    route_ff <= nxt_route;
                end
            end

            assign out_enable[o]             = en_ff;
            assign in_route[o*N_IN +: N_IN]  = route_ff;

            property p_dis_none;
                @(posedge mclk) disable iff (rst)
                !en_ff |-> (route_ff == '0);
            endproperty
            a_dis_none: assert property (p_dis_none) else $error("disabled output routed");

            property p_one_sel;
                @(posedge mclk) disable iff (rst)
                en_ff |-> ($onehot(route_ff) && route_ff[sel_ff]);
            endproperty
            a_one_sel: assert property (p_one_sel) else $error("select decode not one-hot");

            property p_take_word;
                @(posedge mclk) disable iff (rst)
                capture |=> !rs_n || ((en_ff == $past(lnk.word[o*SLOT_W+EN_POS]))
                    && (sel_ff == $past(lnk.word[o*SLOT_W +: SEL_W])));
            endproperty
            a_take_word: assert property (p_take_word) else $error("second rank missed word");
        end
    endgenerate

    // =========================================================
    // checks
    default clocking cb_main @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_cs_freeze;
        (sy2_ff[SY_CE] && rs_n) |=> (!rs_n || ($stable(out_enable) && $stable(in_route)));
    endproperty
    a_cs_freeze: assert property (p_cs_freeze) else $error("second rank moved while deselected");

    property p_close;
        !open_win |=> (st_ff == XP_HOLD);
    endproperty
    a_close: assert property (p_close) else $error("window not closed");

    property p_clear;
        !rank_clear_n |=> ((out_enable == '0) && (in_route == '0));
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not disable outputs");

    property p_wait_pass;
        (st_ff == XP_WAIT && open_win && quiet && !chg) |=> (st_ff == XP_PASS) || !rs_n;
    endproperty
    a_wait_pass: assert property (p_wait_pass) else $error("window failed to follow");

    property p_hold_still;
        (st_ff == XP_HOLD && rs_n) |=> (!rs_n || ($stable(out_enable) && $stable(in_route)));
    endproperty
    a_hold_still: assert property (p_hold_still) else $error("second rank moved outside window");

    property p_busy_still;
        (chg && rs_n) |=> (!rs_n || ($stable(out_enable) && $stable(in_route)));
    endproperty
    a_busy_still: assert property (p_busy_still) else $error("second rank took a moving word");

    property p_follow;
        capture |=> rank_follow;
    endproperty
    a_follow: assert property (p_follow) else $error("capture did not reach follow state");

    property p_state_onehot;
        $onehot(st_ff);
    endproperty
    a_state_onehot: assert property (p_state_onehot) else $error("window state not one-hot");

    property p_pass_open;
        rank_follow |-> $past(open_win);
    endproperty
    a_pass_open: assert property (p_pass_open) else $error("follow state without open window");

    property p_wait_open;
        (st_ff == XP_WAIT) |-> $past(open_win);
    endproperty
    a_wait_open: assert property (p_wait_open) else $error("wait state without open window");

    property p_clear_low;
        !rs_n |-> ((out_enable == '0) && (in_route == '0));
    endproperty
    a_clear_low: assert property (p_clear_low) else $error("outputs enabled while cleared");

    property p_quiet_count;
        (!chg && !quiet) |=> (q_ff == $past(q_ff) + 1'b1);
    endproperty
    a_quiet_count: assert property (p_quiet_count) else $error("quiet counter did not advance");
endmodule

// >>> xp_host_model.sv
// host controller model driving the load pins of the crosspoint programming logic
module xp_host_model import xp_pkg::*; (
    output logic             load_clk,
    output logic             chip_select_n,
    output logic             load_mode_select,
    output logic             serial_in,
    output logic [SEL_W-1:0] output_address,
    output logic [SEL_W-1:0] input_select_bits,
    output logic             output_enable_bit
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // idle levels, load clock parked high
    initial begin
        load_clk          = 1'b1;
        chip_select_n     = 1'b1;
        load_mode_select  = MODE_SERIAL;
        serial_in         = 1'b0;
        output_address    = 4'h0;
        input_select_bits = 4'h0;
        output_enable_bit = 1'b0;
    end

    // ==========================================
    // load clock pulse, 80 ns period, driven whether or not chip select is low
    task automatic pulse();
        #40 load_clk = 1'b0;
        #40 load_clk = 1'b1;
    endtask

    task automatic select(input logic n);
        #13 chip_select_n = n;
    endtask

    task automatic shift_bit(input logic b);
        load_mode_select = MODE_SERIAL;
        serial_in        = b;
        pulse();
    endtask

    task automatic send_word(input logic [SR_BITS-1:0] w);
        for (int i = SR_BITS - 1; i >= 0; i--) begin
            shift_bit(w[i]);
        end
        // released line turns over
        serial_in = ~w[0];
    endtask

    task automatic par_write(input logic [SEL_W-1:0] a, input logic en, input logic [SEL_W-1:0] s);
        #13;
        load_mode_select  = ~MODE_SERIAL;
        output_address    = a;
        output_enable_bit = en;
        input_select_bits = s;
        pulse();
        output_address    = ~a;
        output_enable_bit = ~en;
        input_select_bits = ~s;
    endtask
endmodule

// >>> xp_link_if.sv
// first-rank word and change toggle passed from the load clock side
interface xp_link_if import xp_pkg::*; ();
    logic [SR_BITS-1:0] word;
    logic               chg_tog;
    modport link (output word, output chg_tog);
    modport core (input word, input chg_tog);
endinterface

// >>> xp_link_shift.sv
// first-rank shift register on the falling edge of the load clock
module xp_link_shift import xp_pkg::*; (
    input  wire logic             load_clk,
    input  wire logic             chip_select_n,
    input  wire logic             load_mode_select,
    input  wire logic             serial_in,
    input  wire logic [SEL_W-1:0] output_address,
    input  wire logic [SEL_W-1:0] input_select_bits,
    input  wire logic             output_enable_bit,
    xp_link_if.link               lnk,
    output wire logic             serial_out
);
    // =========================================================
    // first rank
    logic [SR_BITS-1:0] sr_ff;
    logic [SR_BITS-1:0] nxt_sr;
    logic               tog_ff;
    logic               nxt_tog;

    always_comb begin
        nxt_sr  = sr_ff;
        nxt_tog = tog_ff;
        if (!chip_select_n) begin
            if (load_mode_select == MODE_SERIAL) begin
                nxt_sr = {sr_ff[SR_BITS-2:0], serial_in};
            end else begin
                // sampled at the falling edge that closes the load window
                nxt_sr[SLOT_W*output_address +: SLOT_W] =
                    {output_enable_bit, input_select_bits};
            end
            nxt_tog = ~tog_ff;
        end else begin
            // deselected edges park the toggle at a known level
            nxt_tog = 1'b0;
        end
    end

    always_ff @(negedge load_clk) begin
        sr_ff  <= nxt_sr;
        tog_ff <= nxt_tog;
    end

    assign lnk.word    = sr_ff;
    assign lnk.chg_tog = tog_ff;
    assign serial_out  = sr_ff[SR_BITS-1];

    // =========================================================
    // checks
    logic [RUN_W-1:0] run_ff;
    logic [RUN_W-1:0] nxt_run;

    always_comb begin
        nxt_run = '0;
        if (!chip_select_n && load_mode_select == MODE_SERIAL) begin
            nxt_run = run_ff;
            if (run_ff != RUN_W'(SR_BITS)) begin
                nxt_run = run_ff + 1'b1;
            end
        end
    end

    always_ff @(negedge load_clk) begin
        run_ff <= nxt_run;
    end

    default clocking cb_link @(negedge load_clk);
    endclocking

    property p_cs_hold;
        chip_select_n |=> $stable(sr_ff);
    endproperty
    a_cs_hold: assert property (p_cs_hold) else $error("first rank changed while deselected");

    property p_ser_shift;
        (!chip_select_n && load_mode_select == MODE_SERIAL) |=>
            // bits not yet loaded are unknown, so they must move as they are
            (sr_ff[0] == $past(serial_in)) && (sr_ff[SR_BITS-1:1] === $past(sr_ff[SR_BITS-2:0]));
    endproperty
    a_ser_shift: assert property (p_ser_shift) else $error("serial shift wrong");

    property p_ser_delay;
        (run_ff == RUN_W'(SR_BITS)) |-> (serial_out == $past(serial_in, SR_BITS));
    endproperty
    a_ser_delay: assert property (p_ser_delay) else $error("serial out not 80 edges behind");

    property p_par_load;
        (!chip_select_n && load_mode_select != MODE_SERIAL) |=>
            sr_ff[SLOT_W*$past(output_address) +: SLOT_W] ==
            {$past(output_enable_bit), $past(input_select_bits)};
    endproperty
    a_par_load: assert property (p_par_load) else $error("parallel slot load wrong");
endmodule

// >>> xp_pkg.sv
// constants and types shared by the crosspoint programming logic
package xp_pkg;
    localparam int N_OUT   = 16;
    localparam int N_IN    = 16;
    localparam int SEL_W   = 4;
    localparam int SLOT_W  = 5;
    localparam int EN_POS  = 4;
    localparam int SR_BITS = N_OUT * SLOT_W;
    localparam int RUN_W   = 7;
    // link clock timing seen from mclk
    localparam int MCLK_NS     = 40;
    localparam int LINK_MIN_NS = 80;
    localparam int QUIET_CYC   = (2 * LINK_MIN_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int QCNT_W      = 4;
    // synchroniser lanes
    localparam int SY_CE  = 0;
    localparam int SY_UPD = 1;
    localparam int SY_TOG = 2;
    localparam int SY_W   = 3;
    localparam logic [SY_W-1:0] SY_RST = 3'h3;
    localparam logic MODE_SERIAL = 1'b0;
    localparam logic [N_IN-1:0] SEL_BASE = {{(N_IN-1){1'b0}}, 1'b1};
    typedef enum logic [2:0] {
        XP_HOLD = 3'h1,
        XP_WAIT = 3'h2,
        XP_PASS = 3'h4
    } xp_rank_st_t;
endpackage
